// ### hw/flash_rst_host.sv
// Host-side sequencer: holds the flash through power-up and hardware
// resets and only then grants accesses to the user side.
module flash_rst_host #(
  parameter int SUPPLY_CYC = flash_rst_pkg::SUPPLY_SETUP_CYC,
  parameter int RPH_CYC    = flash_rst_pkg::RST_TO_SEL_CYC,
  parameter int RP_CYC     = flash_rst_pkg::RST_LOW_CYC,
  parameter int RH_CYC     = flash_rst_pkg::RST_HIGH_SEL_CYC,
  parameter int CEH_CYC    = flash_rst_pkg::SEL_HIGH_CYC
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic nrst,
  // User side.
  input  wire logic supplies_ok,
  input  wire logic reset_req,
  input  wire logic access_req,
  output logic      access_grant,
  output logic      access_done,
  output logic      ready,
  output logic      reset_timeout,
  // Flash pins.
  input  wire logic ready_busy_n,
  output logic      reset_n,
  output logic      select_n,
  output logic      output_enable_n
);
  localparam int W = flash_rst_pkg::CNT_W;

  // The pin-width helpers saturate at 255, so the pulse figures stay at or below it.
  if (SUPPLY_CYC >= (1 << W) || RPH_CYC >= (1 << W) || SUPPLY_CYC < 1 ||
      RPH_CYC < 1 || RP_CYC < 1 || RH_CYC < 1 || CEH_CYC < 1 ||
      RP_CYC > 255 || RH_CYC > 255) begin : g_bad_cfg
    $error("flash_rst_host: timing parameter out of range");
  end

  typedef enum logic [2:0] {
    S_OFF, S_COLD, S_RST_LOW, S_RST_WAIT, S_RST_HIGH, S_IDLE, S_ACCESS,
    S_SEL_HIGH
  } state_t;

  state_t       state_r, state_nxt;
  logic         rst_n_r, rst_n_nxt;
  logic         sel_n_r, sel_n_nxt;
  logic         done_r, done_nxt;
  logic         to_r, to_nxt;
  logic         ld;
  logic [W-1:0] ld_val;
  logic         t_busy, t_done;

  flash_rst_timer #(.W(W)) u_timer (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (ld),
    .value   (ld_val),
    .busy    (t_busy),
    .done    (t_done)
  );

  // Sequencer. Reset low is held for the pulse, then kept low until the
  // reset-to-select interval less the lead time has run, then high for the select lead time.
  // The host waits for ready/busy as well, which covers a cold reset the
  // device may repeat instead of a warm one.
  always_comb begin
    state_nxt = state_r;
    rst_n_nxt = rst_n_r;
    sel_n_nxt = sel_n_r;
    done_nxt  = 1'b0;
    to_nxt    = to_r;
    ld        = 1'b0;
    ld_val    = '0;
    case (state_r)
      S_OFF: begin
        rst_n_nxt = 1'b0;
        sel_n_nxt = 1'b1;
        to_nxt    = 1'b0;
        if (supplies_ok) begin
          // Hold select high through supply setup; device ignores it.
          ld        = 1'b1;
          ld_val    = W'(SUPPLY_CYC);
          state_nxt = S_COLD;
        end
      end
      S_COLD: begin
        if (t_done) begin
          // Reset-to-select counted from supply setup end.
          ld        = 1'b1;
          ld_val    = W'(RPH_CYC);
          state_nxt = S_RST_WAIT;
        end
      end
      S_RST_LOW: begin
        rst_n_nxt = 1'b0;
        if (t_done) begin
          // Remaining low time so pulse plus lead covers the interval.
          ld        = 1'b1;
          ld_val    = (RPH_CYC > RP_CYC + RH_CYC) ?
                      W'(RPH_CYC - RP_CYC - RH_CYC) : W'(1);
          state_nxt = S_RST_WAIT;
        end
      end
      S_RST_WAIT: begin
        if (t_done) begin
          rst_n_nxt = 1'b1;
          ld        = 1'b1;
          ld_val    = W'(RH_CYC);
          state_nxt = S_RST_HIGH;
        end
      end
      S_RST_HIGH: begin
        // Ready/busy must be released before the first access, unless the extra wait has already run out.
        if (!t_busy && ready_busy_n) begin
          to_nxt    = 1'b0;
          state_nxt = S_IDLE;
        end else if (!t_busy && to_r) begin
          // The extra wait ran out as well; go on and leave the flag set.
          state_nxt = S_IDLE;
        end else if (!t_busy) begin
          // Device is redoing a full cold reset; wait it out once.
          ld        = 1'b1;
          ld_val    = W'(SUPPLY_CYC);
          to_nxt    = 1'b1;
        end
      end
      S_IDLE: begin
        if (reset_req) begin
          // Warm reset aborts embedded work in the device.
          // A fresh reset earns a fresh extra wait.
          rst_n_nxt = 1'b0;
          to_nxt    = 1'b0;
          ld        = 1'b1;
          ld_val    = W'(RP_CYC);
          state_nxt = S_RST_LOW;
        end else if (access_req) begin
          sel_n_nxt = 1'b0; // Falling select starts access.
          state_nxt = S_ACCESS;
        end
      end
      S_ACCESS: begin
        sel_n_nxt = 1'b1;
        done_nxt  = 1'b1;
        ld        = 1'b1;
        ld_val    = W'(CEH_CYC);
        state_nxt = S_SEL_HIGH;
      end
      S_SEL_HIGH: begin
        if (!t_busy) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_OFF;
    endcase
    if (!supplies_ok) begin
      state_nxt = S_OFF;
      rst_n_nxt = 1'b0;
      sel_n_nxt = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_OFF;
      rst_n_r <= 1'b0;
      sel_n_r <= 1'b1;
      done_r  <= 1'b0;
      to_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rst_n_r <= rst_n_nxt;
      sel_n_r <= sel_n_nxt;
      done_r  <= done_nxt;
      to_r    <= to_nxt;
    end
  end

  assign reset_n         = rst_n_r;
  assign select_n        = sel_n_r;
  assign output_enable_n = sel_n_r;
  assign access_done     = done_r;
  assign access_grant    = (state_r == S_IDLE) && access_req && !reset_req;
  assign ready           = (state_r == S_IDLE);
  assign reset_timeout   = to_r;

  // Helpers: cycles reset has been high and low; both saturate.
  logic [7:0] hi_cnt_r, hi_cnt_nxt;
  logic [7:0] lo_cnt_r, lo_cnt_nxt;
  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    lo_cnt_nxt = lo_cnt_r;
    if (!rst_n_r) begin
      hi_cnt_nxt = '0;
      if (lo_cnt_r != 8'hff) lo_cnt_nxt = lo_cnt_r + 8'h01;
    end else begin
      lo_cnt_nxt = '0;
      if (hi_cnt_r != 8'hff) hi_cnt_nxt = hi_cnt_r + 8'h01;
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
    end
  end

  sequence sel_fall_s;
    $fell(sel_n_r);
  endsequence

  rst_lead_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sel_fall_s |-> hi_cnt_r >= 8'(RH_CYC))
    else $error("select fell too soon after reset rose");
  sel_high_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(sel_n_r) |=> sel_n_r [*1] ##1 sel_n_r)
    else $error("select high pulse too short");
  sel_in_rst_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rst_n_r |-> sel_n_r)
    else $error("select low while reset low");
  rst_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(rst_n_r) && supplies_ok && $past(supplies_ok) |->
      !rst_n_r [*4] ##1 !rst_n_r)
    else $error("reset pulse too short");
  rst_width_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(rst_n_r) |-> lo_cnt_r >= 8'(RP_CYC))
    else $error("reset low shorter than pulse width");
  busy_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sel_fall_s |-> $past(ready_busy_n))
    else $error("access started while busy");
  off_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !supplies_ok |=> sel_n_r && !rst_n_r)
    else $error("pins active without supplies");
  done_pulse_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    sel_fall_s |=> access_done ##1 !access_done)
    else $error("access done not one cycle");
  grant_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    access_grant |=> !sel_n_r)
    else $error("grant without select");
endmodule : flash_rst_host

// ### hw/flash_rst_pkg.sv
// Function
// - Host starts access by select falling after cold.
// - Optional reset pulse at least 200 ns.
// - Reset-to-select measured from supply setup end.
// - Reset high 50 ns before select falls.
// - Pulse plus high delay covers reset-to-select.
// - Select high at least 20 ns between accesses.
// - Hardware reset begins on reset pin low.
package flash_rst_pkg;
  localparam int CLK_MHZ                   = 50;
  localparam int SUPPLY_SETUP_TIME_US      = 300;
  localparam int RESET_TO_SELECT_TIME_US   = 35;
  localparam int RESET_LOW_PULSE_WIDTH_NS  = 200;
  localparam int RESET_HIGH_TO_SELECT_NS   = 50;
  localparam int SELECT_HIGH_PULSE_WIDTH_NS = 20;
  localparam int NS_PER_CYCLE              = 1000 / CLK_MHZ;
  // Least times round up to whole cycles.
  localparam int SUPPLY_SETUP_CYC  = SUPPLY_SETUP_TIME_US * CLK_MHZ;
  localparam int RST_TO_SEL_CYC    = RESET_TO_SELECT_TIME_US * CLK_MHZ;
  localparam int RST_LOW_CYC       =
    (RESET_LOW_PULSE_WIDTH_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int RST_HIGH_SEL_CYC  =
    (RESET_HIGH_TO_SELECT_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int SEL_HIGH_CYC      =
    (SELECT_HIGH_PULSE_WIDTH_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int CNT_W             = 16;
endpackage : flash_rst_pkg

// ### hw/flash_rst_timer.sv
// Down counter: load a count, done flags the last of its counted cycles.
module flash_rst_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Control.
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Status.
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // The one-bit end marker below needs at least two bits of count.
  if (W < 2) begin : g_bad_width
    $error("flash_rst_timer: counter too narrow");
  end

  // Load wins over counting so a restart is never lost.
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done marks the last cycle, so a load of N spans exactly N cycles and
  // the caller acts on the edge that closes them.
  assign busy = (cnt_r != '0);
  assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule : flash_rst_timer

// ### test/flash_dev_model.sv
// Behavioural flash: reset state machine seen only through ready/busy.
module flash_dev_model #(
  parameter int COLD_CYC = 40,
  parameter int WARM_CYC = 12
) (
  // Clock of the host, used as a time base only.
  input  wire logic clk_sys,
  // Supplies and host pins.
  input  wire logic supplies_ok,
  input  wire logic reset_n,
  // Forces the power-on reset to fail at the next supply rise.
  input  wire logic por_fail,
  // Open-drain status with pull-up.
  output logic      ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt_r    = 0;
  logic por_ok_r = 1'b0;
  logic sup_r    = 1'b0;
  logic rst_r    = 1'b0;

  // Busy count; controls are ignored while it runs, so a reset that
  // lands inside a cold reset only lets the cold reset finish.
  always @(posedge clk_sys) begin
    sup_r <= supplies_ok;
    rst_r <= reset_n;
    if (!supplies_ok) begin
      cnt_r    <= 0;
      por_ok_r <= 1'b0;
    end else if (!sup_r) begin
      cnt_r    <= COLD_CYC;
      por_ok_r <= !por_fail;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end else if (rst_r && !reset_n) begin
      cnt_r    <= por_ok_r ? WARM_CYC : COLD_CYC;
      por_ok_r <= 1'b1;
    end
  end

  // Released pin reads high through the pull-up, never a stale value.
  assign ready_busy_n = (cnt_r == 0) &&
                        por_ok_r;
endmodule : flash_dev_model

// ### test/flash_rst_host_tb.sv
// Self-checking bench for the host reset sequencer.
module flash_rst_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SUP = 50;
  localparam int RPH = 20;
  localparam int RH  = 3;
  localparam int COLD = 40;
  logic clk_sys, nrst, supplies_ok, reset_req, access_req, por_fail;
  logic access_grant, access_done, ready, reset_timeout;
  logic ready_busy_n, reset_n, select_n, output_enable_n;
  logic oe_lo;
  int   n_fail, checks, waited, lo, hi, gap;
  logic [7:0] q_acc[$];
  logic [7:0] q_rst[$];

  flash_rst_host #(.SUPPLY_CYC(SUP), .RPH_CYC(RPH), .RP_CYC(10),
    .RH_CYC(RH), .CEH_CYC(1)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .supplies_ok(supplies_ok), .reset_req(reset_req),
    .access_req(access_req), .access_grant(access_grant),
    .access_done(access_done), .ready(ready),
    .reset_timeout(reset_timeout), .ready_busy_n(ready_busy_n),
    .reset_n(reset_n), .select_n(select_n),
    .output_enable_n(output_enable_n));
  flash_dev_model #(.COLD_CYC(COLD), .WARM_CYC(12)) flash (
    .clk_sys(clk_sys), .supplies_ok(supplies_ok), .reset_n(reset_n),
    .por_fail(por_fail), .ready_busy_n(ready_busy_n));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task end_sim();
    n_fail += q_acc.size() + q_rst.size();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Bounded wait for the idle state; the wait length is kept.
  task wait_ready(input int lim);
    waited = 0;
    do begin
      @(negedge clk_sys);
      waited++;
    end while (ready !== 1'b1 && waited < lim);
    chk(8'h1, {7'h0, ready});
  endtask : wait_ready

  // Observer: pin widths are measured here and paired with the notes.
  always @(negedge clk_sys) begin
    if (!select_n) begin
      if (hi > 0) gap = hi;
      hi = 0;
      oe_lo = !output_enable_n;
    end else hi++;
    if (!reset_n) lo++;
    else begin
      if (lo > 0 && q_rst.size() > 0)
        chk(q_rst.pop_front(), 8'(lo));
      lo = 0;
    end
    // Output enable must have gone low with select during the strobe.
    if (access_done === 1'b1 && q_acc.size() > 0) begin
      chk(q_acc.pop_front(), {3'h0, oe_lo, reset_n, ready_busy_n,
        select_n, 1'(gap >= 2)});
      oe_lo = 1'b0;
    end
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    supplies_ok = 1'b0;
    reset_req = 1'b0;
    access_req = 1'b0;
    por_fail = 1'b0;
    n_fail = 0;
    checks = 0;
    lo = 0;
    hi = 0;
    gap = 0;
    oe_lo = 1'b0;
    void'($urandom(32'hccd035bc));
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys) supplies_ok <= 1'b1;
    wait_ready(400);
    chk(8'h1, {7'h0, ready_busy_n});
    chk(8'h0, {7'h0, reset_timeout});
    // Accesses with random spacing, some back to back.
    repeat (8) begin
      repeat ($urandom % 4) @(posedge clk_sys);
      @(posedge clk_sys) access_req <= 1'b1;
      q_acc.push_back(8'h1f);
      @(negedge clk_sys) chk(8'h1, {7'h0, access_grant});
      @(posedge clk_sys) access_req <= 1'b0;
      wait_ready(20);
    end
    // Warm reset raced by an access request: reset wins.
    @(posedge clk_sys) reset_req <= 1'b1;
    access_req <= 1'b1;
    q_rst.push_back(8'(RPH - RH));
    @(negedge clk_sys) chk(8'h0, {7'h0, access_grant});
    @(posedge clk_sys) reset_req <= 1'b0;
    access_req <= 1'b0;
    // The device is into its warm reset by now and shows busy.
    repeat (3) @(negedge clk_sys);
    chk(8'h0, {7'h0, ready_busy_n});
    wait_ready(100);
    chk(8'h1, {7'h0, ready_busy_n});
    // Power cycle with a failed power-on reset, then a hardware reset.
    @(posedge clk_sys) supplies_ok <= 1'b0;
    por_fail <= 1'b1;
    repeat (5) @(posedge clk_sys);
    supplies_ok <= 1'b1;
    @(posedge clk_sys) por_fail <= 1'b0;
    wait_ready(600);
    chk(8'h1, {7'h0, reset_timeout});
    @(posedge clk_sys) reset_req <= 1'b1;
    q_rst.push_back(8'(RPH - RH));
    @(posedge clk_sys) reset_req <= 1'b0;
    wait_ready(200);
    chk(8'h1, {7'h0, 1'(waited >= COLD - 2)});
    chk(8'h1, {7'h0, ready_busy_n});
    @(posedge clk_sys) access_req <= 1'b1;
    q_acc.push_back(8'h1f);
    @(negedge clk_sys) chk(8'h1, {7'h0, access_grant});
    @(posedge clk_sys) access_req <= 1'b0;
    wait_ready(20);
    end_sim();
  end
endmodule : flash_rst_host_tb
